// ### core/sbi_defs.svh
// constants of the processor system bus pin interface
// assumes inclusion by bare name from the package only; the core files use its macros without including it
`ifndef SBI_DEFS_SVH
`define SBI_DEFS_SVH

// bus widths of the multiplexed interface
`define SBI_AD_W      64
`define SBI_CMD_W     9
`define SBI_CHK_W     8
// width used when the strap selects the narrow bus
`define SBI_NARROW_W  32
`define SBI_NARROW_CW 4
// flip-flops in the strap synchroniser
`define SBI_SYNC_LEN  3
// level of the width strap that selects the narrow bus
`define SBI_STRAP_NARROW 1'b1

`endif

// ### core/sbi_pkg.sv
// types shared by the system bus interface core
// assumes the constants header sits beside it on the include path
package sbi_pkg;
  `include "sbi_defs.svh"

  // request from the processor core: one address cycle, one data cycle for writes
  typedef struct packed {
    logic                  write;
    logic [`SBI_CMD_W-1:0] cmd;
    logic [`SBI_AD_W-1:0]  addr;
    logic [`SBI_AD_W-1:0]  data;
  } sbi_req_t;

  // word taken from the external agent while the bus is released
  typedef struct packed {
    logic [`SBI_CMD_W-1:0] id;
    logic [`SBI_AD_W-1:0]  data;
    logic                  check_ok;
  } sbi_rsp_t;

  typedef enum logic [1:0] {
    SBI_IDLE,
    SBI_ADDR,
    SBI_WDATA,
    SBI_SLAVE
  } sbi_state_t;
endpackage

// ### core/sbi_strap_sync.sv
// three-stage synchroniser for a static strap pin
// assumes the strap is stable long before any transfer is started
`timescale 1ns/1ns
module sbi_strap_sync
  import sbi_pkg::*;
#(
  parameter int unsigned STAGES = `SBI_SYNC_LEN
) (
  input  wire logic clk,      // system interface clock
  input  wire logic srst,     // synchronous reset, active high
  input  wire logic pin_in,   // raw strap level
  output logic      level_out // filtered strap level
);
  // refused at elaboration: fewer stages cannot give two settled flops to compare
  if (STAGES < 3) begin : g_stage_check
    $error("sbi_strap_sync needs at least three stages");
  end

  logic [STAGES-1:0] sync_reg;
  logic [STAGES-1:0] sync_next;
  logic              level_reg;
  logic              level_next;

  // ****************************************************************
  // shift chain and agreement filter
  // ****************************************************************
  // only the last two stages are compared, the first one may be metastable
  always_comb begin
    sync_next  = {sync_reg[STAGES-2:0], pin_in};
    level_next = level_reg;
    if (sync_reg[STAGES-2] == sync_reg[STAGES-1]) begin
      level_next = sync_reg[STAGES-1];
    end
  end

  // reset picks the narrow bus, the safe side until the strap is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_reg  <= {STAGES{`SBI_STRAP_NARROW}};
      level_reg <= `SBI_STRAP_NARROW;
    end else begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule

// ### core/sbi_core.sv
// device end of the multiplexed processor system bus
// assumes the agent drives and samples every pin on the rising edge of clk
//
// Overview of operation
// - addresses and data share one 64-bit multiplexed bus.
// - narrow strap drives upper 32 bus lanes low in address and input cycles.
// - command or word identifier travels on a separate 9-bit bus.
// - driver of the data places byte parity on the 8-bit check bus.
// - narrow strap drives upper four check lanes low in address and input cycles.
// - command parity pin is unused and driven low whenever the device drives the bus.
// - device asserts its valid strobe exactly while driving valid bus values.
// - device asserts release when it hands over the bus and turns slave.
`timescale 1ns/1ns
module sbi_core
  import sbi_pkg::*;
#(
  parameter int unsigned AD_W  = `SBI_AD_W,
  parameter int unsigned CHK_W = `SBI_CHK_W
) (
  input  wire logic              clk,                  // system interface clock
  input  wire logic              srst,                 // synchronous reset, active high
  input  wire logic              req_valid,            // core offers a request
  input  wire sbi_req_t          req,                  // request contents
  output logic                   req_ready,            // request may be taken
  output logic                   rsp_valid,            // one-cycle pulse, word received
  output sbi_rsp_t               rsp,                  // received word
  input  wire logic [AD_W-1:0]   sys_addr_data_in,     // address/data bus level
  output logic [AD_W-1:0]        sys_addr_data_out,    // address/data bus drive value
  output logic [AD_W-1:0]        sys_addr_data_oe,     // per-lane drive enable
  input  wire logic [`SBI_CMD_W-1:0] sys_command_id_in,  // command bus level
  output logic [`SBI_CMD_W-1:0]  sys_command_id_out,   // command bus drive value
  output logic                   sys_command_id_oe,    // command bus drive enable
  input  wire logic [CHK_W-1:0]  sys_check_bits_in,    // check bus level
  output logic [CHK_W-1:0]       sys_check_bits_out,   // check bus drive value
  output logic [CHK_W-1:0]       sys_check_bits_oe,    // per-lane check drive enable
  input  wire logic              command_parity_in,    // unused parity pin level
  output logic                   command_parity_out,   // always low
  output logic                   command_parity_oe,    // parity pin drive enable
  input  wire logic              agent_valid_n,        // agent drives valid values
  output logic                   proc_valid_n,         // device drives valid values
  input  wire logic              agent_bus_request_n,  // agent wants the bus
  output logic                   release_n,            // bus handed to the agent
  input  wire logic              write_accept_n,       // agent takes a write
  input  wire logic              read_accept_n,        // agent takes a read
  input  wire logic              narrow_width_sel_n    // strap, high selects 32-bit
);
  localparam int unsigned NW = `SBI_NARROW_W;
  localparam int unsigned NC = `SBI_NARROW_CW;

  // the request and response structs fix the bus at the package width
  if (AD_W != `SBI_AD_W || AD_W != 8 * CHK_W) begin : g_width_check
    $error("sbi_core needs the package bus width and one check bit per byte");
  end
  if (AD_W <= NW || CHK_W <= NC) begin : g_narrow_check
    $error("sbi_core bus narrower than narrow mode");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // even parity over each byte lane
  function automatic logic [CHK_W-1:0] byte_parity(input logic [AD_W-1:0] d);
    logic [CHK_W-1:0] p;
    p = '0;
    for (int i = 0; i < CHK_W; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction

  // clears the upper lanes when the narrow bus is in use
  function automatic logic [AD_W-1:0] lanes(input logic [AD_W-1:0] d, input logic nar);
    logic [AD_W-1:0] r;
    r = d;
    if (nar) begin
      r[AD_W-1:NW] = '0;
    end
    return r;
  endfunction

  logic narrow;
  sbi_strap_sync #(
    .STAGES (`SBI_SYNC_LEN)
  ) u_strap (
    .clk       (clk),
    .srst      (srst),
    .pin_in    (narrow_width_sel_n),
    .level_out (narrow)
  );

  sbi_state_t            state_reg, state_next;
  sbi_req_t              hold_reg, hold_next;
  logic                  rd_pend_reg, rd_pend_next;
  logic                  ready_reg, ready_next;
  logic                  rsp_valid_reg, rsp_valid_next;
  sbi_rsp_t              rsp_reg, rsp_next;
  logic [AD_W-1:0]       ad_out_reg, ad_out_next, ad_oe_reg, ad_oe_next;
  logic [`SBI_CMD_W-1:0] cmd_out_reg, cmd_out_next;
  logic                  cmd_oe_reg, cmd_oe_next;
  logic [CHK_W-1:0]      chk_out_reg, chk_out_next, chk_oe_reg, chk_oe_next;
  logic                  cpar_oe_reg, cpar_oe_next;
  logic                  valid_n_reg, valid_n_next;
  logic                  release_n_reg, release_n_next;
  logic                  upper_low;
  logic                  take_req;

  // a request goes only when the agent has signalled it will accept that kind
  assign take_req = (state_reg == SBI_IDLE) && agent_bus_request_n && req_valid && ready_reg
                    && (req.write ? !write_accept_n : !read_accept_n);

  // ****************************************************************
  // bus sequencer
  // ****************************************************************
  // every pin value is computed one cycle ahead so all outputs but the constant-low parity value leave flops
  always_comb begin
    state_next     = state_reg;
    hold_next      = hold_reg;
    rd_pend_next   = rd_pend_reg;
    rsp_next       = rsp_reg;
    rsp_valid_next = 1'b0;
    ad_out_next    = '0;
    ad_oe_next     = '0;
    cmd_out_next   = '0;
    cmd_oe_next    = 1'b0;
    chk_out_next   = '0;
    chk_oe_next    = '0;
    cpar_oe_next   = 1'b0;
    valid_n_next   = 1'b1;
    release_n_next = 1'b1;
    upper_low      = 1'b0;
    unique case (state_reg)
      SBI_IDLE: begin
        if (!agent_bus_request_n) begin
          state_next     = SBI_SLAVE;
          release_n_next = 1'b0;
          upper_low      = 1'b1;
        end else if (take_req) begin
          hold_next    = req;
          state_next   = SBI_ADDR;
          ad_out_next  = lanes(req.addr, narrow);
          ad_oe_next   = '1;
          cmd_out_next = req.cmd;
          cmd_oe_next  = 1'b1;
          chk_oe_next  = '1;
          cpar_oe_next = 1'b1;
          valid_n_next = 1'b0;
        end
      end
      SBI_ADDR: begin
        if (hold_reg.write) begin
          state_next   = SBI_WDATA;
          ad_out_next  = lanes(hold_reg.data, narrow);
          ad_oe_next   = '1;
          cmd_out_next = hold_reg.cmd;
          cmd_oe_next  = 1'b1;
          chk_out_next = byte_parity(lanes(hold_reg.data, narrow));
          chk_oe_next  = '1;
          cpar_oe_next = 1'b1;
          valid_n_next = 1'b0;
        end else begin
          // read: hand the bus over so the agent can return the word
          state_next     = SBI_SLAVE;
          rd_pend_next   = 1'b1;
          release_n_next = 1'b0;
          upper_low      = 1'b1;
        end
      end
      SBI_WDATA: begin
        state_next = SBI_IDLE;
      end
      SBI_SLAVE: begin
        upper_low = 1'b1;
        if (!agent_valid_n) begin
          rsp_next.id       = sys_command_id_in;
          rsp_next.data     = lanes(sys_addr_data_in, narrow);
          rsp_next.check_ok = byte_parity(lanes(sys_addr_data_in, narrow))
                              == (narrow ? {{(CHK_W-NC){1'b0}}, sys_check_bits_in[NC-1:0]}
                                         : sys_check_bits_in);
          rsp_valid_next    = 1'b1;
          if (rd_pend_reg) begin
            rd_pend_next = 1'b0;
            state_next   = SBI_IDLE;
            upper_low    = 1'b0;
          end
        end else if (!rd_pend_reg && agent_bus_request_n) begin
          // agent has let go and sends nothing more, take the bus back
          state_next = SBI_IDLE;
          upper_low  = 1'b0;
        end
      end
    endcase
    // data input cycles on the narrow bus: unused lanes held low by us
    if (upper_low && narrow) begin
      ad_oe_next[AD_W-1:NW]   = '1;
      chk_oe_next[CHK_W-1:NC] = '1;
      cpar_oe_next            = 1'b1;
    end
    ready_next = (state_next == SBI_IDLE);
  end

  // ****************************************************************
  // state and pin registers
  // ****************************************************************
  // everything changes on the rising edge only, as the agent expects
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= SBI_IDLE;
      hold_reg      <= '0;
      rd_pend_reg   <= 1'b0;
      ready_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
      ad_out_reg    <= '0;
      ad_oe_reg     <= '0;
      cmd_out_reg   <= '0;
      cmd_oe_reg    <= 1'b0;
      chk_out_reg   <= '0;
      chk_oe_reg    <= '0;
      cpar_oe_reg   <= 1'b0;
      valid_n_reg   <= 1'b1;
      release_n_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      hold_reg      <= hold_next;
      rd_pend_reg   <= rd_pend_next;
      ready_reg     <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg       <= rsp_next;
      ad_out_reg    <= ad_out_next;
      ad_oe_reg     <= ad_oe_next;
      cmd_out_reg   <= cmd_out_next;
      cmd_oe_reg    <= cmd_oe_next;
      chk_out_reg   <= chk_out_next;
      chk_oe_reg    <= chk_oe_next;
      cpar_oe_reg   <= cpar_oe_next;
      valid_n_reg   <= valid_n_next;
      release_n_reg <= release_n_next;
    end
  end

  // pins straight from flops; the parity pin is never used, its value stays low
  assign req_ready          = ready_reg;
  assign rsp_valid          = rsp_valid_reg;
  assign rsp                = rsp_reg;
  assign sys_addr_data_out  = ad_out_reg;
  assign sys_addr_data_oe   = ad_oe_reg;
  assign sys_command_id_out = cmd_out_reg;
  assign sys_command_id_oe  = cmd_oe_reg;
  assign sys_check_bits_out = chk_out_reg;
  assign sys_check_bits_oe  = chk_oe_reg;
  assign command_parity_out = 1'b0;
  assign command_parity_oe  = cpar_oe_reg;
  assign proc_valid_n       = valid_n_reg;
  assign release_n          = release_n_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_narrow_upper_low;
    @(posedge clk) disable iff (srst)
    (narrow && (sys_addr_data_oe[AD_W-1:NW] != '0)) |-> (sys_addr_data_out[AD_W-1:NW] == '0);
  endproperty
  a_narrow_upper_low: assert property (p_narrow_upper_low)
    else $error("upper bus lanes not low on narrow bus");

  property p_narrow_slave_drive;
    @(posedge clk) disable iff (srst)
    (narrow && state_reg == SBI_SLAVE && $past(state_reg) == SBI_SLAVE && $past(narrow))
      |-> (sys_addr_data_oe[AD_W-1:NW] == '1) && (sys_check_bits_oe[CHK_W-1:NC] == '1)
          && (sys_check_bits_out[CHK_W-1:NC] == '0);
  endproperty
  a_narrow_slave_drive: assert property (p_narrow_slave_drive)
    else $error("narrow input cycle leaves upper lanes undriven");

  property p_cmd_parity;
    @(posedge clk) disable iff (srst)
    sys_addr_data_oe[0] |-> command_parity_oe && !command_parity_out;
  endproperty
  a_cmd_parity: assert property (p_cmd_parity)
    else $error("command parity pin not driven low with the bus");

  property p_valid_means_drive;
    @(posedge clk) disable iff (srst)
    !proc_valid_n |-> (sys_addr_data_oe == '1) && (state_reg inside {SBI_ADDR, SBI_WDATA});
  endproperty
  a_valid_means_drive: assert property (p_valid_means_drive)
    else $error("valid out without driving the bus");

  property p_cmd_with_valid;
    @(posedge clk) disable iff (srst)
    !proc_valid_n |-> sys_command_id_oe && (sys_command_id_out == hold_reg.cmd);
  endproperty
  a_cmd_with_valid: assert property (p_cmd_with_valid)
    else $error("command bus not driven with valid out");

  property p_release_slave;
    @(posedge clk) disable iff (srst)
    $fell(release_n) |-> (state_reg == SBI_SLAVE) && !sys_command_id_oe ##1 release_n;
  endproperty
  a_release_slave: assert property (p_release_slave)
    else $error("release without entering slave state");

  property p_write_walk;
    @(posedge clk) disable iff (srst)
    (take_req && req.write) ##1 (!proc_valid_n && sys_addr_data_out == lanes(hold_reg.addr, narrow))
      |=> !proc_valid_n && (sys_check_bits_out == byte_parity(sys_addr_data_out))
          ##1 proc_valid_n && (sys_addr_data_oe == '0 || narrow);
  endproperty
  a_write_walk: assert property (p_write_walk)
    else $error("write address and data cycles out of step");

  property p_read_walk;
    @(posedge clk) disable iff (srst)
    (take_req && !req.write) |-> ##1 !proc_valid_n ##1 (!release_n && proc_valid_n);
  endproperty
  a_read_walk: assert property (p_read_walk)
    else $error("read not followed by release two cycles later");

  property p_slave_quiet;
    @(posedge clk) disable iff (srst)
    (state_reg == SBI_SLAVE) |-> (sys_addr_data_oe[NW-1:0] == '0) && proc_valid_n;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("device drives low lanes while slave");
endmodule

// ### bench/sbi_agent_model.sv
// external agent model facing the system bus core
// assumes the bench resolves each shared line from the device's drive enables alone
`timescale 1ns/1ns
module sbi_agent_model
  import sbi_pkg::*;
(
  input  wire logic        clk,                 // system interface clock
  input  wire logic        srst,                // synchronous reset
  input  wire logic        accept_en,           // accept processor requests
  input  wire logic        want_bus,            // ask for the interface
  input  wire logic        bad_parity,          // corrupt check bit 0
  input  wire logic [3:0]  ret_delay,           // idle cycles before a read answer
  input  wire logic [3:0]  nwords,              // words per slave burst
  input  wire logic [63:0] base,                // first data word
  input  wire logic [8:0]  base_id,             // first identifier
  input  wire logic        release_n,           // device hands over the bus
  output logic             agent_bus_request_n, // request line
  output logic             agent_valid_n,       // valid strobe
  output logic             write_accept_n,      // write accept
  output logic             read_accept_n,       // read accept
  output logic [63:0]      ag_data,             // bus drive value
  output logic [7:0]       ag_chk,              // check drive value
  output logic [8:0]       ag_cmd               // identifier drive value
);
  logic [3:0]  left;
  logic [3:0]  dly;
  logic [3:0]  k;
  logic [63:0] w;

  assign w = base + 64'(k);

  function automatic logic [7:0] par8(input logic [63:0] d);
    for (int i = 0; i < 8; i++) par8[i] = ^d[8*i +: 8];
  endfunction

  // ************************************************
  // agent behaviour
  // ************************************************
  // released lines invert each cycle so a stale word never reads as fresh
  always_ff @(posedge clk) begin
    if (srst) begin
      {agent_bus_request_n, agent_valid_n, write_accept_n, read_accept_n} <= 4'hF;
      {ag_data, ag_chk, ag_cmd} <= '0;
      left <= 4'h0;
      dly  <= 4'h0;
      k    <= 4'h0;
    end else begin
      write_accept_n            <= ~accept_en;
      read_accept_n             <= ~accept_en;
      agent_bus_request_n       <= ~want_bus;
      agent_valid_n             <= 1'b1;
      {ag_data, ag_chk, ag_cmd} <= ~{ag_data, ag_chk, ag_cmd};
      if (!release_n) begin
        // no own request pending: the release means a read answer is owed
        left <= agent_bus_request_n ? 4'h1 : nwords;
        dly  <= agent_bus_request_n ? ret_delay : 4'h0;
        k    <= 4'h0;
      end else if (left != 4'h0 && dly != 4'h0) begin
        dly <= dly - 4'h1;
      end else if (left != 4'h0) begin
        agent_valid_n <= 1'b0;
        ag_data       <= w;
        ag_cmd        <= base_id + 9'(k);
        ag_chk        <= par8(w) ^ {7'h00, bad_parity};
        left          <= left - 4'h1;
        k             <= k + 4'h1;
      end
    end
  end
endmodule

// ### bench/sbi_core_bench.sv
// self-checking bench for the system bus core
// assumes the agent model beside it; the parity pin has a board pull-down
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module sbi_core_bench
  import sbi_pkg::*;
  ;
  logic        clk = 1'b0, srst = 1'b1, req_valid = 1'b0, strap = 1'b0;
  logic        accept_en = 1'b1, want_bus = 1'b0, bad_parity = 1'b0;
  logic [3:0]  ret_delay = 4'h0, nwords = 4'h1;
  logic [63:0] base = 64'h0;
  logic [8:0]  base_id = 9'h0;
  sbi_req_t    req = '0;
  sbi_rsp_t    rsp, q[$];
  int          mismatches = 0, checks = 0, cyc = 0, q_cyc[$];
  logic        req_ready, rsp_valid, cp_out, cp_oe, proc_valid_n, release_n, cmd_oe;
  logic        agent_bus_request_n, agent_valid_n, write_accept_n, read_accept_n;
  logic [63:0] ad_out, ad_oe, ag_data, ad_bus;
  logic [8:0]  cmd_out, ag_cmd, cmd_bus;
  logic [7:0]  chk_out, chk_oe, ag_chk, chk_bus;

  // ************************************************
  // wires, clock and monitor
  // ************************************************
  assign ad_bus  = (ad_out & ad_oe) | (ag_data & ~ad_oe);
  assign chk_bus = (chk_out & chk_oe) | (ag_chk & ~chk_oe);
  assign cmd_bus = cmd_oe ? cmd_out : ag_cmd;

  always #2 clk = ~clk;

  // received words are logged mid-cycle, when every output has settled
  always @(negedge clk) begin
    cyc++;
    if (rsp_valid === 1'b1) begin
      q.push_back(rsp);
      q_cyc.push_back(cyc);
    end
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  sbi_core dut_u (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .sys_addr_data_in(ad_bus),
    .sys_addr_data_out(ad_out), .sys_addr_data_oe(ad_oe), .sys_command_id_in(cmd_bus),
    .sys_command_id_out(cmd_out), .sys_command_id_oe(cmd_oe),
    .sys_check_bits_in(chk_bus), .sys_check_bits_out(chk_out), .sys_check_bits_oe(chk_oe),
    .command_parity_in(cp_oe ? cp_out : 1'b0), .command_parity_out(cp_out),
    .command_parity_oe(cp_oe), .agent_valid_n(agent_valid_n), .proc_valid_n(proc_valid_n),
    .agent_bus_request_n(agent_bus_request_n), .release_n(release_n),
    .write_accept_n(write_accept_n), .read_accept_n(read_accept_n),
    .narrow_width_sel_n(strap));

  sbi_agent_model agent_u (
    .clk(clk), .srst(srst), .accept_en(accept_en), .want_bus(want_bus),
    .bad_parity(bad_parity), .ret_delay(ret_delay), .nwords(nwords), .base(base),
    .base_id(base_id), .release_n(release_n), .agent_bus_request_n(agent_bus_request_n),
    .agent_valid_n(agent_valid_n), .write_accept_n(write_accept_n),
    .read_accept_n(read_accept_n), .ag_data(ag_data), .ag_chk(ag_chk), .ag_cmd(ag_cmd));

  function automatic logic [7:0] par8(input logic [63:0] d);
    for (int i = 0; i < 8; i++) par8[i] = ^d[8*i +: 8];
  endfunction

  // ************************************************
  // tasks
  // ************************************************
  // holds the request until the edge that takes it, returns mid first address cycle
  task automatic issue(input logic wr, input logic [63:0] a, d, input logic [8:0] c);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req = sbi_req_t'{write: wr, cmd: c, addr: a, data: d};
    while (!(req_ready === 1'b1 && agent_bus_request_n === 1'b1 &&
             (wr ? write_accept_n : read_accept_n) === 1'b0) && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic wait_rsp(input int n);
    int t;
    t = 0;
    while (q.size() < n && t < 40) begin
      @(negedge clk);
      t++;
    end
  endtask

  task automatic t_write(input logic nar, input logic [63:0] a, d, input logic [8:0] c);
    logic [63:0] wd;
    wd = nar ? {32'h0, d[31:0]} : d;
    issue(1'b1, a, d, c);
    `CHK("wr addr", nar ? {32'h0, a[31:0]} : a, ad_out)
    `CHK("wr addr oe", {64{1'b1}}, ad_oe)
    `CHK("wr addr check", 8'h00, chk_out)
    `CHK("wr cmd", c, cmd_out)
    `CHK("wr cmd oe", 1'b1, cmd_oe)
    `CHK("wr addr valid", 1'b0, proc_valid_n)
    `CHK("wr parity pin", 1'b0, cp_out)
    @(negedge clk);
    `CHK("wr data", wd, ad_out)
    `CHK("wr check", par8(wd), chk_out)
    `CHK("wr data valid", 1'b0, proc_valid_n)
    @(negedge clk);
    `CHK("wr end valid", 1'b1, proc_valid_n)
    `CHK("wr end oe", 64'h0, ad_oe)
  endtask

  task automatic t_read(input logic nar, input logic [63:0] a, input logic [3:0] dl,
                        input logic [63:0] b, input logic [8:0] idv, input logic bad);
    ret_delay = dl;
    base = b;
    base_id = idv;
    bad_parity = bad;
    q.delete();
    issue(1'b0, a, 64'h0, 9'h0A5);
    `CHK("rd addr", nar ? {32'h0, a[31:0]} : a, ad_out)
    `CHK("rd cmd", 9'h0A5, cmd_out)
    @(negedge clk);
    `CHK("rd release", 1'b0, release_n)
    `CHK("rd valid off", 1'b1, proc_valid_n)
    `CHK("rd lane oe", nar ? {{32{1'b1}}, 32'h0} : 64'h0, ad_oe)
    `CHK("rd upper zero", 32'h0, ad_out[63:32] & ad_oe[63:32])
    `CHK("rd check oe", nar ? 8'hF0 : 8'h00, chk_oe)
    `CHK("rd parity oe", nar, cp_oe)
    @(negedge clk);
    `CHK("rd release once", 1'b1, release_n)
    wait_rsp(1);
    `CHK("rd data", nar ? {32'h0, b[31:0]} : b, q[0].data)
    `CHK("rd id", idv, q[0].id)
    `CHK("rd parity", ~bad, q[0].check_ok)
  endtask

  task automatic t_slave(input logic nar, input logic [3:0] n, input logic bad);
    int k;
    nwords = n;
    base = 64'hF0E1_D2C3_B4A5_9687;
    base_id = 9'h1A0;
    bad_parity = bad;
    q.delete();
    q_cyc.delete();
    want_bus = 1'b1;
    k = 0;
    while (release_n !== 1'b0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK("slave release", 1'b0, release_n)
    `CHK("slave lane oe", nar ? {{32{1'b1}}, 32'h0} : 64'h0, ad_oe)
    `CHK("slave cmd oe", 1'b0, cmd_oe)
    wait_rsp(n);
    want_bus = 1'b0;
    // the bus must come back before the agent may ask again
    repeat (3) @(negedge clk);
    `CHK("slave return", 1'b1, req_ready)
    for (k = 0; k < n; k++) begin
      `CHK("slave data", nar ? {32'h0, base[31:0] + 32'(k)} : base + 64'(k), q[k].data)
      `CHK("slave id", base_id + 9'(k), q[k].id)
      `CHK("slave parity", ~bad, q[k].check_ok)
      `CHK("slave spacing", q_cyc[0] + k, q_cyc[k])
    end
  endtask

  // a write offered while the agent refuses must wait without touching the bus
  task automatic t_stall();
    accept_en = 1'b0;
    fork
      t_write(1'b0, 64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210, 9'h0C3);
      begin
        repeat (6) begin
          @(negedge clk);
          `CHK("stall no drive", 1'b1, proc_valid_n)
        end
        `CHK("stall ready", 1'b1, req_ready)
        accept_en = 1'b1;
      end
    join
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    t_write(1'b0, 64'h8000_0000_1234_5678, 64'h0102_0304_0506_0780, 9'h011);
    t_write(1'b0, {64{1'b1}}, 64'h0, 9'h1FF);
    t_read(1'b0, 64'h0000_0040_0000_0100, 4'h0, 64'hA5A5_0F0F_3C3C_1111, 9'h155, 1'b0);
    t_read(1'b0, 64'h0000_0000_0000_0108, 4'h5, 64'h1357_9BDF_0246_8ACE, 9'h0AA, 1'b1);
    t_stall();
    t_slave(1'b0, 4'h3, 1'b0);
    t_slave(1'b0, 4'h1, 1'b1);
    strap = 1'b1;
    repeat (6) @(negedge clk);
    t_write(1'b1, 64'hDEAD_0000_BEEF_0010, 64'hCAFE_F00D_8421_7E7E, 9'h0F0);
    t_read(1'b1, 64'h0000_1111_0000_2220, 4'h2, 64'h7777_8888_9999_AAAA, 9'h033, 1'b0);
    t_slave(1'b1, 4'h2, 1'b0);
    end_sim();
  end
endmodule
